// File: rtl/hbss_defs.vh
// Constants for the hub boot strap sequencer
`ifndef HBSS_DEFS_VH
`define HBSS_DEFS_VH

// Flash signature location and boot entry
`define HBSS_SIG_ADDR      16'hfffa
`define HBSS_EXEC_ADDR     16'h0000
`define HBSS_SIG_LEN       3'h4
// Signature bytes in address order
`define HBSS_SIG_B0        8'h32
`define HBSS_SIG_B1        8'h44
`define HBSS_SIG_B2        8'h46
`define HBSS_SIG_B3        8'h55
// Flash read command and divider
`define HBSS_CMD_READ      8'h03
`define HBSS_SCK_HALF      2'h1
// ROM defaults table
`define HBSS_ROM_WORDS     5'h10
`define HBSS_ROM_AW        4
// Merge settle time in cycles
`define HBSS_MERGE_CYC     4'h4
// Reset values
`define HBSS_RST_STRAP     1'b0

`endif

// File: rtl/hbss_rom.v
// Defaults ROM with registered read data
`timescale 1ns/10ps
module hbss_rom (
  core_clk,
  rd_addr,
  rd_data
);
  input  wire       core_clk;   // System clock
  input  wire [3:0] rd_addr;    // Word address
  output reg  [7:0] rd_data;    // Registered read data

  // ----------------------------------------
  // Table lookup
  // ----------------------------------------
  always @(posedge core_clk) begin
    rd_data <= {rd_addr, 4'ha} ^ 8'h5c;
  end
endmodule // hbss_rom

// File: rtl/hbss_sequencer.v
// Reset, strap capture and boot stage sequencer
`timescale 1ns/10ps
`include "hbss_defs.vh"

module hbss_sequencer (
  core_clk,
  sys_rst,
  chip_rst_n,
  non_removable_strap,
  charge_enable_strap,
  flash_boot_strap,
  flash_dual,
  cfg_done,
  vbus_present,
  soft_disconnect,
  host_run,
  swap_pin_req,
  swap_auto_req,
  spi_ce_n,
  spi_clk,
  spi_do,
  spi_do_oe_n,
  spi_di,
  spi_d1_out,
  spi_d1_oe_n,
  standby,
  pll_run,
  port_if_oe_n,
  port1_non_removable,
  port1_charge_en,
  port2_charge_en,
  port2_overcurrent_sense_en,
  swap_go,
  flash_exec,
  exec_addr,
  rom_loaded,
  cfg_byte,
  cfg_valid,
  merged,
  host_attach,
  normal_op,
  stage
);
  input  wire       core_clk;                    // System clock
  input  wire       sys_rst;                     // Synchronous reset, high
  input  wire       chip_rst_n;                  // Chip reset pin, low = standby
  input  wire       non_removable_strap;         // Strap level
  input  wire       charge_enable_strap;         // Strap level
  input  wire       flash_boot_strap;            // Flash boot allowed
  input  wire       flash_dual;                  // Use 2-bit data read
  input  wire       cfg_done;                    // External config finished
  input  wire       vbus_present;                // Upstream bus power
  input  wire       soft_disconnect;             // Upstream soft disconnect
  input  wire       host_run;                    // Host moves hub to normal
  input  wire       swap_pin_req;                // Pin-commanded swap
  input  wire       swap_auto_req;               // New host detected
  output reg        spi_ce_n;                    // Flash select, low active
  output reg        spi_clk;                     // Flash clock, idles low
  output reg        spi_do;                      // Data 0 out
  output reg        spi_do_oe_n;                 // Data 0 enable, low drives
  input  wire       spi_di;                      // Data 1 in
  input  wire       spi_d1_out;                  // Data 0 in during dual phase
  output wire       spi_d1_oe_n;                 // Data 1 never driven
  output wire       standby;                     // Standby indicator
  output wire       pll_run;                     // PLL enable
  output wire       port_if_oe_n;                // Port pin enable, low drives
  output wire       port1_non_removable;         // Port 1 fixed
  output wire       port1_charge_en;             // Port 1 charging
  output wire       port2_charge_en;             // Port 2 charging
  output wire       port2_overcurrent_sense_en;  // Port 2 sense
  output reg        swap_go;                     // Swap pulse
  output reg        flash_exec;                  // Executing from flash
  output reg [15:0] exec_addr;                   // Flash entry address
  output reg        rom_loaded;                  // Defaults loaded
  output reg  [7:0] cfg_byte;                    // Loaded default byte
  output reg        cfg_valid;                   // Default byte strobe
  output reg        merged;                      // Merge complete
  output reg        host_attach;                 // Host attach bit
  output reg        normal_op;                   // Normal operation
  output wire [6:0] stage;                       // One-hot stage

  // ----------------------------------------
  // Stage codes
  // ----------------------------------------
  localparam [6:0] ST_STBY  = 7'h01;  // Standby
  localparam [6:0] ST_PROBE = 7'h02;  // Flash probe
  localparam [6:0] ST_ROM   = 7'h04;  // ROM defaults
  localparam [6:0] ST_WAIT  = 7'h08;  // Wait config done
  localparam [6:0] ST_MERGE = 7'h10;  // Merge
  localparam [6:0] ST_ATT   = 7'h20;  // Host attach
  localparam [6:0] ST_NORM  = 7'h40;  // Normal

  reg  [6:0]  stage_ff;       // Current stage
  reg  [6:0]  nxt_stage;      // Next stage
  reg         nrem_ff;        // Captured strap
  reg         chg_ff;         // Captured strap
  reg         rstn_d_ff;      // Previous pin level
  reg  [5:0]  bit_ff;         // Flash bit counter
  reg  [1:0]  div_ff;         // Flash clock divider
  reg  [39:0] sh_ff;          // Flash shift register
  reg         probe_done_ff;  // Probe finished
  reg         sig_ok_ff;      // Signature match
  reg  [3:0]  rom_a_ff;       // ROM address
  reg         rom_v_ff;       // ROM read pending
  reg         rom_end_ff;     // Last ROM word addressed
  reg  [3:0]  mcnt_ff;        // Merge timer
  wire [7:0]  rom_q;          // ROM data
  wire        hub_mode;       // Reset pin high and sys_rst low
  wire        rel;            // Reset release edge
  wire [31:0] sig_word;       // Expected signature

  assign hub_mode = chip_rst_n & ~sys_rst;
  assign rel      = chip_rst_n & ~rstn_d_ff;
  assign sig_word = {`HBSS_SIG_B0, `HBSS_SIG_B1, `HBSS_SIG_B2, `HBSS_SIG_B3};
  assign stage    = stage_ff;
  assign standby  = stage_ff[0];
  assign pll_run  = ~stage_ff[0];
  assign port_if_oe_n = stage_ff[0];
  assign spi_d1_oe_n  = 1'b1;
  assign port1_non_removable = nrem_ff;
  assign port1_charge_en     = chg_ff;
  assign port2_charge_en     = 1'b0;
  assign port2_overcurrent_sense_en = 1'b0;

  // ----------------------------------------
  // Defaults ROM
  // ----------------------------------------
  hbss_rom u_rom (
    .core_clk (core_clk),
    .rd_addr  (rom_a_ff),
    .rd_data  (rom_q)
  );

  // ----------------------------------------
  // Strap capture on release edge
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      rstn_d_ff <= 1'b0;
      nrem_ff   <= `HBSS_RST_STRAP;
      chg_ff    <= `HBSS_RST_STRAP;
    end else begin
      rstn_d_ff <= chip_rst_n;
      if (rel) begin
        nrem_ff <= non_removable_strap;
        chg_ff  <= charge_enable_strap;
      end
    end
  end

  // ----------------------------------------
  // Swap gating
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst || !chip_rst_n) begin
      swap_go <= 1'b0;
    end else begin
      swap_go <= normal_op & (swap_pin_req | (swap_auto_req & chg_ff));
    end
  end

  // ----------------------------------------
  // Stage sequencing
  // ----------------------------------------
  always @* begin
    nxt_stage = stage_ff;
    case (stage_ff)
      ST_STBY: begin
        if (hub_mode) begin
          nxt_stage = ST_PROBE;
        end
      end
      ST_PROBE: begin
        if (!flash_boot_strap || probe_done_ff) begin
          nxt_stage = ST_ROM;
        end
      end
      ST_ROM: begin
        if (rom_loaded) begin
          nxt_stage = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cfg_done) begin
          nxt_stage = ST_MERGE;
        end
      end
      ST_MERGE: begin
        if (merged) begin
          nxt_stage = ST_ATT;
        end
      end
      ST_ATT: begin
        if (!vbus_present) begin
          nxt_stage = ST_ATT;
        end else if (host_run && !soft_disconnect) begin
          nxt_stage = ST_NORM;
        end
      end
      ST_NORM: begin
        if (soft_disconnect || !vbus_present) begin
          nxt_stage = ST_ATT;
        end
      end
      default: begin
        nxt_stage = ST_STBY;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (!hub_mode) begin
      stage_ff <= ST_STBY;
    end else begin
      stage_ff <= nxt_stage;
    end
  end

  // ----------------------------------------
  // Flash probe: read 4 bytes from signature address
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!hub_mode || stage_ff != ST_PROBE) begin
      spi_ce_n      <= 1'b1;
      spi_clk       <= 1'b0;
      spi_do        <= 1'b0;
      spi_do_oe_n   <= 1'b1;
      bit_ff        <= 6'h00;
      div_ff        <= 2'h0;
      sh_ff         <= 40'h0;
      if (!hub_mode) begin
        probe_done_ff <= 1'b0;
        sig_ok_ff     <= 1'b0;
      end
    end else if (flash_boot_strap && !probe_done_ff) begin
      spi_ce_n <= 1'b0;
      if (bit_ff == 6'h00 && spi_ce_n) begin
        sh_ff       <= {`HBSS_CMD_READ, `HBSS_SIG_ADDR, 16'h0000};
        spi_do_oe_n <= 1'b0;
      end else if (div_ff == `HBSS_SCK_HALF) begin
        div_ff  <= 2'h0;
        spi_clk <= ~spi_clk;
        if (!spi_clk) begin
          // Rising edge: sample data
          if (bit_ff >= 6'h18) begin
            spi_do_oe_n <= 1'b1;
            if (flash_dual) begin
              sh_ff  <= {sh_ff[37:0], spi_di, spi_d1_out};
              bit_ff <= bit_ff + 6'h02;
            end else begin
              sh_ff  <= {sh_ff[38:0], spi_di};
              bit_ff <= bit_ff + 6'h01;
            end
          end else begin
            bit_ff <= bit_ff + 6'h01;
          end
        end else begin
          // Falling edge: launch next command bit
          spi_do <= sh_ff[39];
          if (bit_ff < 6'h18) begin
            sh_ff <= {sh_ff[38:0], 1'b0};
          end
        end
        if (bit_ff >= 6'h38) begin
          probe_done_ff <= 1'b1;
          sig_ok_ff     <= (sh_ff[31:0] == sig_word);
          spi_ce_n      <= 1'b1;
        end
      end else begin
        div_ff <= div_ff + 2'h1;
        if (bit_ff == 6'h00) begin
          spi_do <= sh_ff[39];
          sh_ff  <= {sh_ff[38:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------
  // Flash execution, ROM load, merge, attach
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!hub_mode) begin
      flash_exec  <= 1'b0;
      exec_addr   <= `HBSS_EXEC_ADDR;
      rom_loaded  <= 1'b0;
      rom_a_ff    <= 4'h0;
      rom_v_ff    <= 1'b0;
      rom_end_ff  <= 1'b0;
      cfg_byte    <= 8'h00;
      cfg_valid   <= 1'b0;
      merged      <= 1'b0;
      mcnt_ff     <= 4'h0;
      host_attach <= 1'b0;
      normal_op   <= 1'b0;
    end else begin
      cfg_valid <= 1'b0;
      if (stage_ff == ST_PROBE && probe_done_ff && sig_ok_ff) begin
        flash_exec <= 1'b1;
        exec_addr  <= `HBSS_EXEC_ADDR;
      end
      if (stage_ff == ST_ROM && !rom_loaded) begin
        rom_v_ff <= 1'b1;
        if (rom_v_ff) begin
          cfg_byte  <= rom_q;
          cfg_valid <= 1'b1;
        end
        // Last word comes out one cycle after its address, so finish a cycle later
        if ({1'b0, rom_a_ff} == `HBSS_ROM_WORDS - 5'h01) begin
          rom_end_ff <= 1'b1;
          rom_loaded <= rom_end_ff;
        end else begin
          rom_a_ff <= rom_a_ff + 4'h1;
        end
      end
      if (stage_ff == ST_MERGE) begin
        if (mcnt_ff == `HBSS_MERGE_CYC) begin
          merged <= 1'b1;
        end else begin
          mcnt_ff <= mcnt_ff + 4'h1;
        end
      end
      if (stage_ff == ST_ATT || stage_ff == ST_NORM) begin
        host_attach <= 1'b1;
      end
      normal_op <= (nxt_stage == ST_NORM);
    end
  end
endmodule // hbss_sequencer

// File: dv/hbss_asserts.sv
// Port checker for the hub boot strap sequencer
`timescale 1ns/10ps
module hbss_asserts (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       chip_rst_n,
  input wire logic       non_removable_strap,
  input wire logic       charge_enable_strap,
  input wire logic       flash_boot_strap,
  input wire logic       cfg_done,
  input wire logic       soft_disconnect,
  input wire logic       swap_pin_req,
  input wire logic       swap_auto_req,
  input wire logic       standby,
  input wire logic       pll_run,
  input wire logic       port_if_oe_n,
  input wire logic       port1_non_removable,
  input wire logic       port1_charge_en,
  input wire logic       port2_charge_en,
  input wire logic       port2_overcurrent_sense_en,
  input wire logic       swap_go,
  input wire logic       flash_exec,
  input wire logic       host_attach,
  input wire logic [6:0] stage
);
  // ----------------------------------------
  // Properties, one clock domain
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_stby_entry: assert property (
    !chip_rst_n |=> stage == 7'h01 && standby && !pll_run && port_if_oe_n) else $error("standby not entered");
  a_port2_off: assert property (
    !port2_charge_en && !port2_overcurrent_sense_en) else $error("port 2 feature enabled");
  a_strap_take: assert property (
    $rose(chip_rst_n) |=> port1_non_removable == $past(non_removable_strap)
      && port1_charge_en == $past(charge_enable_strap)) else $error("strap not captured");
  a_strap_hold: assert property (
    chip_rst_n && $past(chip_rst_n) && $past(chip_rst_n, 2) |-> $stable(port1_non_removable)
      && $stable(port1_charge_en)) else $error("strap value moved");
  a_release_probe: assert property (
    $rose(chip_rst_n) |=> stage == 7'h02) else $error("no probe after release");
  a_skip_flash: assert property (
    stage == 7'h02 && !flash_boot_strap && chip_rst_n |=> stage == 7'h04) else $error("probe not skipped");
  a_stage_order: assert property (
    stage != $past(stage) |-> stage == 7'h01 || stage == {$past(stage[5:0]), 1'b0}
      || (stage == 7'h20 && $past(stage) == 7'h40)) else $error("stage out of order");
  a_cfg_merge: assert property (
    stage == 7'h08 && cfg_done && chip_rst_n |=> stage == 7'h10) else $error("merge not started");
  a_attach_bit: assert property (
    stage == 7'h20 && $past(stage) == 7'h20 |-> host_attach) else $error("attach bit low");
  a_disc_back: assert property (
    stage == 7'h40 && soft_disconnect && chip_rst_n |=> stage == 7'h20) else $error("no return to attach");
  a_swap_cause: assert property (
    swap_go |-> $past(swap_pin_req || (swap_auto_req && port1_charge_en))) else $error("swap without cause");
  // Main scenarios reached
  c_normal: cover property (stage == 7'h40);
  c_flash: cover property (flash_exec);
  c_swap: cover property (swap_go);
endmodule // hbss_asserts

bind hbss_sequencer hbss_asserts u_hbss_asserts (
  .core_clk(core_clk), .sys_rst(sys_rst), .chip_rst_n(chip_rst_n),
  .non_removable_strap(non_removable_strap), .charge_enable_strap(charge_enable_strap),
  .flash_boot_strap(flash_boot_strap), .cfg_done(cfg_done), .soft_disconnect(soft_disconnect),
  .swap_pin_req(swap_pin_req), .swap_auto_req(swap_auto_req), .standby(standby), .pll_run(pll_run),
  .port_if_oe_n(port_if_oe_n), .port1_non_removable(port1_non_removable),
  .port1_charge_en(port1_charge_en), .port2_charge_en(port2_charge_en),
  .port2_overcurrent_sense_en(port2_overcurrent_sense_en), .swap_go(swap_go),
  .flash_exec(flash_exec), .host_attach(host_attach), .stage(stage));

// File: dv/hbss_flash_model.sv
// Behavioural serial boot flash answering the probe
`timescale 1ns/10ps
`include "hbss_defs.vh"
module hbss_flash_model (
  input  wire logic spi_ce_n,   // Select, low active
  input  wire logic spi_clk,    // Serial clock
  input  wire logic spi_do,     // Command and address in
  input  wire logic dual,       // Two data bits per clock
  input  wire logic bad_sig,    // Corrupt first signature byte
  output logic      spi_di,     // Data out, upper bit
  output logic      spi_d1_out  // Data out, lower bit in dual
);
  logic [23:0] hdr;  // Command and address shifted in
  logic [7:0]  b;    // Byte being sent
  int          cnt;  // Header bits taken
  int          k;    // Data bits sent
  initial begin
    spi_di = 1'b0;
    spi_d1_out = 1'b0;
    cnt = 0;
    k = 0;
  end
  // Image: signature at the top of the probed page
  function automatic logic [7:0] mem(input logic [15:0] a);
    case (a)
      `HBSS_SIG_ADDR: mem = `HBSS_SIG_B0 ^ {7'h00, bad_sig};
      `HBSS_SIG_ADDR + 16'h1: mem = `HBSS_SIG_B1;
      `HBSS_SIG_ADDR + 16'h2: mem = `HBSS_SIG_B2;
      `HBSS_SIG_ADDR + 16'h3: mem = `HBSS_SIG_B3;
      default: mem = 8'hff;
    endcase
  endfunction
  // Header sampled on the rising clock
  always @(posedge spi_clk) begin
    if (!spi_ce_n && cnt < 24) begin
      hdr = {hdr[22:0], spi_do};
      cnt = cnt + 1;
    end
  end
  // Data launched on the falling clock, MSB first
  always @(negedge spi_clk) begin
    if (!spi_ce_n && cnt == 24) begin
      b = mem(hdr[15:0] + 16'(k / 8));
      spi_di = b[7 - k % 8];
      spi_d1_out = dual ? b[6 - k % 8] : ~spi_d1_out;
      k = k + (dual ? 2 : 1);
    end
  end
  // Deselect restarts and stops showing old bits
  always @(spi_ce_n) begin
    cnt = 0;
    k = 0;
    spi_di = ~spi_di;
    spi_d1_out = ~spi_d1_out;
  end
endmodule // hbss_flash_model

// File: dv/tb_top.sv
// Directed bench for the hub boot strap sequencer
`timescale 1ns/10ps
`include "hbss_defs.vh"
module tb_top;
  logic core_clk = 0, sys_rst = 1, chip_rst_n = 0, nr = 0, bc = 0, fb = 0, dual = 0, bad = 0;
  logic cfg_done = 0, vbus = 0, sdisc = 0, hrun = 0, spin = 0, sauto = 0;
  wire  ce_n, sck, sdo, sdo_oe_n, sdi, sd0, stby, pll, pif, p1nr, p1bc, p2bc, p2ocs;
  wire  swp, fexec, rom_ld, cval, merged, attach, norm, d1oe;
  wire  [15:0] eaddr;
  wire  [6:0]  stage;
  wire  do_line = sdo_oe_n ? 1'b1 : sdo;  // Pulled-up data line
  int   error_cnt = 0, check_count = 0, cyc = 0, vcnt = 0;

  hbss_sequencer u_hbss_sequencer (
    .core_clk(core_clk), .sys_rst(sys_rst), .chip_rst_n(chip_rst_n),
    .non_removable_strap(nr), .charge_enable_strap(bc), .flash_boot_strap(fb),
    .flash_dual(dual), .cfg_done(cfg_done), .vbus_present(vbus), .soft_disconnect(sdisc),
    .host_run(hrun), .swap_pin_req(spin), .swap_auto_req(sauto), .spi_ce_n(ce_n),
    .spi_clk(sck), .spi_do(sdo), .spi_do_oe_n(sdo_oe_n), .spi_di(sdi), .spi_d1_out(sd0),
    .spi_d1_oe_n(d1oe), .standby(stby), .pll_run(pll), .port_if_oe_n(pif),
    .port1_non_removable(p1nr), .port1_charge_en(p1bc), .port2_charge_en(p2bc),
    .port2_overcurrent_sense_en(p2ocs), .swap_go(swp), .flash_exec(fexec), .exec_addr(eaddr),
    .rom_loaded(rom_ld), .cfg_byte(), .cfg_valid(cval), .merged(merged),
    .host_attach(attach), .normal_op(norm), .stage(stage));
  hbss_flash_model u_flash (.spi_ce_n(ce_n), .spi_clk(sck), .spi_do(do_line), .dual(dual),
    .bad_sig(bad), .spi_di(sdi), .spi_d1_out(sd0));

  always #25 core_clk = ~core_clk;
  // Default-byte strobe count and hang limit
  always @(posedge core_clk) begin
    if (cval === 1'b1) vcnt <= vcnt + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wait_stage(input logic [6:0] s);
    int i;
    for (i = 0; i < 3000 && stage !== s; i++) tick(1);
    chk(stage, s, "stage");
  endtask
  // One boot from standby to normal operation
  task automatic session(input logic n, b, f, d, x);
    chip_rst_n = 0;
    {nr, bc, fb, dual, bad} = {n, b, f, d, x};
    {cfg_done, vbus, sdisc, hrun} = 4'b0100;
    tick(2);
    chk(stage, 7'h01, "standby");
    chk({stby, pll, pif, ce_n, sdo_oe_n, attach, norm, merged, rom_ld, fexec, d1oe}, 11'h5c1, "idle");
    vcnt = 0;
    chip_rst_n = 1;
    tick(1);
    {nr, bc} = ~{n, b};
    chk(stage, 7'h02, "probe");
    chk({p1nr, p1bc, p2bc, p2ocs}, {n, b, 2'b00}, "straps");
    if (!f) begin
      tick(1);
      chk(stage, 7'h04, "skip");
    end
    wait_stage(7'h08);
    tick(1);
    chk({rom_ld, vcnt[4:0]}, {1'b1, `HBSS_ROM_WORDS}, "rom");
    chk({fexec, eaddr}, {f & ~x, `HBSS_EXEC_ADDR}, "flash");
    cfg_done = 1;
    wait_stage(7'h20);
    chk(merged, 1'b1, "merge");
    {vbus, hrun} = 2'b01;
    tick(4);
    chk({stage, attach}, {7'h20, 1'b1}, "attach");
    vbus = 1;
    wait_stage(7'h40);
    chk(norm, 1'b1, "normal");
    sauto = 1;
    tick(2);
    chk(swp, b, "auto swap");
    {sauto, spin} = 2'b01;
    tick(2);
    chk(swp, 1'b1, "pin swap");
    {spin, sdisc} = 2'b01;
    tick(4);
    chk(stage, 7'h20, "disconnect");
    sdisc = 0;
    wait_stage(7'h40);
    chk({p1nr, p1bc}, {n, b}, "held");
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence: boots, then a reset in mid-probe
  initial begin
    tick(6);
    sys_rst = 0;
    session(0, 0, 0, 0, 0);
    session(0, 1, 1, 1, 1);
    session(1, 0, 1, 1, 0);
    session(1, 1, 1, 0, 0);
    chip_rst_n = 0;
    tick(2);
    chip_rst_n = 1;
    tick(30);
    chk({stage, ce_n}, {7'h02, 1'b0}, "probing");
    chip_rst_n = 0;
    tick(1);
    chk({stage, ce_n}, {7'h01, 1'b1}, "abort");
    final_report();
  end
endmodule // tb_top
